/* File: hw/ppl_lane_ctrl.v */
// PIPE lane control top: APB registers, power states, idle, detect, compliance and rate control.
// Contract
// R1: Rate select 00 to 01 starts a switch from 2.5 to 5 Gbps.
// R2: Rate select 01 to 00 starts a switch back to 2.5 Gbps.
// R3: Electrical idle request holds the transmitter in electrical idle.
// R4: Each lane has its own power state request among P0, P0s, P1, P2.
// R5: Packet data moves only in P0; the MAC side picks low-power states.
// R6: The only low-power saving is transmitter electrical idle.
// R7: In compliance the transmitter sends the pattern through the 8b/10b encoder.
// R8: Coding and analog status merge into a 3-bit PCIe receiver status code.
// R9: The MAC side holds the detect request high throughout Detect.
// R10: Detect request in P1 starts a far-end receiver detection.
// R11: In P1 the transmitter stays idle, detection included.
// R12: Bonded lanes share clock and reset; one lane runs non-bonded.
// R13: Widths x1, x2, x4, x8 and x16 work at all three rates.
// R14: Lower rates use the 8b/10b path; 8 Gbps uses 128b/130b.
// R15: Coding-to-analog path is 10 bits at lower rates, 32 at 8 Gbps.
// R16: 8b/10b with running disparity only at the two lower rates.
// R17: At 8 Gbps the MAC side scrambles and descrambles.
// R18: The MAC side infers receiver electrical idle at every rate.
// R19: 5 Gbps lanes switch 2.5/5; 8 Gbps lanes switch among all three.
// R20: At 5 and 8 Gbps de-emphasis -3.5/-6 dB and margining are selectable.
// R21: Receive path absorbs up to 300 ppm clock difference at all rates.
// R22: A phy status pulse marks a finished rate change.
// R23: The MAC side holds rate select until the phy status pulse.
//
// Decided for this implementation: register access over APB and the register offsets.
`timescale 1ns/10ps
`include "ppl_lane_defs.vh"
module ppl_lane_ctrl (
  input  wire                   pclk,
  input  wire                   presetn,
  input  wire                   psel,
  input  wire                   penable,
  input  wire                   pwrite,
  input  wire [`PPL_ADDR_W-1:0] paddr,
  input  wire [31:0]            pwdata,
  output reg  [31:0]            prdata,
  output wire                   pready,
  output reg                    pslverr,
  input  wire                   tx_fifo_empty,
  input  wire                   pma_rate_done,
  input  wire                   rx_detect_done,
  input  wire                   rx_detect_present,
  input  wire                   decode_err,
  input  wire                   disparity_err,
  input  wire                   fifo_overflow,
  input  wire                   fifo_underflow,
  input  wire                   skp_added,
  input  wire                   skp_removed,
  output wire [1:0]             pma_rate_req,
  output wire                   pma_req_valid,
  output wire                   coding_reset,
  output wire                   clk_shutdown,
  output reg                    tx_elec_idle,
  output reg                    rx_detect_start,
  output reg                    compliance_send,
  output reg                    packet_enable,
  output reg                    legacy_coding_datapath,
  output reg                    high_rate_coding_datapath,
  output reg                    disparity_enable,
  output reg  [5:0]             parallel_width,
  output reg                    deemph_6db,
  output reg  [2:0]             tx_margin,
  output reg                    rate_match_enable,
  output reg                    lane_bonded,
  output reg  [4:0]             lane_count,
  output wire [2:0]             rx_status_code,
  output reg                    phy_status_pulse
);

  // Rates a lane may switch to, given its configured top rate.
  function rate_ok;
    input [1:0] rate;
    input [1:0] max_rate;
    begin
      rate_ok = (rate != 2'h3) && (rate <= max_rate);
    end
  endfunction

  // Lane count from the width code; codes above three are clamped to sixteen.
  function [4:0] width_lanes;
    input [2:0] code;
    begin
      case (code)
        3'h0:    width_lanes = 5'h01;
        3'h1:    width_lanes = 5'h02;
        3'h2:    width_lanes = 5'h04;
        3'h3:    width_lanes = 5'h08;
        default: width_lanes = 5'h10;
      endcase
    end
  endfunction

  reg  [`PPL_CTRL_W-1:0] ctrl_q;
  reg  [`PPL_CFG_W-1:0]  cfg_q;
  reg  [2:0]             sync1_q;
  reg  [2:0]             sync2_q;
  reg                    det_done_q;
  reg                    det_req_q;
  reg                    det_present_q;
  reg                    det_valid_q;
  reg                    det_active_q;
  reg                    rate_done_q;
  reg                    det_done_flag_q;
  reg  [2:0]             rxs_hold_q;

  wire       wr_en;
  wire       rd_en;
  wire       addr_ok;
  wire [1:0] req_rate;
  wire [1:0] pwr_state;
  wire       eidle_req;
  wire       det_req;
  wire       compl_req;
  wire [1:0] max_rate;
  wire [1:0] cur_rate;
  wire       sw_busy;
  wire       sw_done;
  wire       sw_start;
  wire       pma_done_s;
  wire       det_done_s;
  wire       det_present_s;
  wire       det_done_rise;
  wire       legacy_rate;
  wire       ctrl_hit;
  wire       status_w1c;
  wire       detect_w1c;

  assign req_rate  = ctrl_q[`PPL_CTRL_RATE_LSB+1:`PPL_CTRL_RATE_LSB];
  assign pwr_state = ctrl_q[`PPL_CTRL_PWR_LSB+1:`PPL_CTRL_PWR_LSB]; // R4
  assign eidle_req = ctrl_q[`PPL_CTRL_EIDLE_BIT];
  assign det_req   = ctrl_q[`PPL_CTRL_DETECT_BIT];
  assign compl_req = ctrl_q[`PPL_CTRL_COMPL_BIT];
  assign max_rate  = cfg_q[`PPL_CFG_MAXR_LSB+1:`PPL_CFG_MAXR_LSB];

  // APB slave: zero wait states, unmapped addresses answer with an error.
  assign pready     = 1'b1;
  assign wr_en      = psel && penable && pwrite;
  assign rd_en      = psel && !pwrite;
  assign addr_ok    = (paddr == `PPL_ADDR_CTRL) || (paddr == `PPL_ADDR_CFG) ||
                      (paddr == `PPL_ADDR_STATUS) || (paddr == `PPL_ADDR_DETECT);
  assign ctrl_hit   = wr_en && (paddr == `PPL_ADDR_CTRL);
  assign status_w1c = wr_en && (paddr == `PPL_ADDR_STATUS) && pwdata[7];
  assign detect_w1c = wr_en && (paddr == `PPL_ADDR_DETECT) && pwdata[2];

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= `PPL_CTRL_RST;
      cfg_q  <= `PPL_CFG_RST;
    end else begin
      if (ctrl_hit)
        ctrl_q <= pwdata[`PPL_CTRL_W-1:0];
      if (wr_en && (paddr == `PPL_ADDR_CFG) && !sw_busy)
        cfg_q <= pwdata[`PPL_CFG_W-1:0];
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h00000000;
      pslverr <= 1'b0;
    end else begin
      pslverr <= psel && !penable && !addr_ok;
      if (psel && !penable) begin
        prdata <= 32'h00000000;
        if (rd_en) begin
          case (paddr)
            `PPL_ADDR_CTRL:   prdata <= {21'h000000, ctrl_q};
            `PPL_ADDR_CFG:    prdata <= {26'h0000000, cfg_q};
            `PPL_ADDR_STATUS: prdata <= {20'h00000, lane_count, rate_done_q,
                                         rxs_hold_q, sw_busy, cur_rate};
            `PPL_ADDR_DETECT: prdata <= {29'h00000000, det_done_flag_q,
                                         det_present_q, det_active_q};
            default:          prdata <= 32'h00000000;
          endcase
        end
      end
    end
  end

  // Analog-side levels cross into pclk through two flops; only the second stage is read.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_q    <= 3'h0;
      sync2_q    <= 3'h0;
      det_done_q <= 1'b0;
    end else begin
      sync1_q    <= {rx_detect_present, rx_detect_done, pma_rate_done};
      sync2_q    <= sync1_q;
      det_done_q <= sync2_q[1];
    end
  end

  assign pma_done_s    = sync2_q[0];
  assign det_done_s    = sync2_q[1];
  assign det_present_s = sync2_q[2];
  assign det_done_rise = det_done_s && !det_done_q;

  // A new rate is taken only when legal for the lane and no switch is running.
  assign sw_start = !sw_busy && (req_rate != cur_rate) &&
                    rate_ok(req_rate, max_rate); // R1 R2 R19

  ppl_rate_switch u_rate_switch (
    .pclk          (pclk),
    .presetn       (presetn),
    .start         (sw_start),
    .target_rate   (req_rate),
    .tx_fifo_empty (tx_fifo_empty),
    .pma_done      (pma_done_s),
    .cur_rate      (cur_rate),
    .pma_rate_req  (pma_rate_req),
    .pma_req_valid (pma_req_valid),
    .coding_reset  (coding_reset),
    .clk_shutdown  (clk_shutdown),
    .busy          (sw_busy),
    .done_pulse    (sw_done)
  );

  assign legacy_rate = (cur_rate != `PPL_RATE_8G);

  // Receiver detection: a rising request in P1 starts one detect sequence.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      det_req_q       <= 1'b0;
      rx_detect_start <= 1'b0;
      det_active_q    <= 1'b0;
      det_present_q   <= 1'b0;
      det_valid_q     <= 1'b0;
      det_done_flag_q <= 1'b0;
    end else begin
      det_req_q       <= det_req;
      rx_detect_start <= det_req && !det_req_q && !det_active_q &&
                         (pwr_state == `PPL_PWR_P1); // R10
      if (det_req && !det_req_q && !det_active_q && (pwr_state == `PPL_PWR_P1))
        det_active_q <= 1'b1;
      else if (det_done_rise)
        det_active_q <= 1'b0;
      det_valid_q <= det_done_rise && det_active_q;
      if (det_done_rise && det_active_q)
        det_present_q <= det_present_s;
      // A completion in the clearing cycle keeps the flag set.
      if (det_done_rise && det_active_q)
        det_done_flag_q <= 1'b1;
      else if (detect_w1c)
        det_done_flag_q <= 1'b0;
    end
  end

  ppl_rx_status u_rx_status (
    .pclk           (pclk),
    .presetn        (presetn),
    .detect_done    (det_valid_q),
    .detect_present (det_present_q),
    .decode_err     (decode_err),
    .disparity_err  (disparity_err),
    .fifo_overflow  (fifo_overflow),
    .fifo_underflow (fifo_underflow),
    .skp_added      (skp_added),
    .skp_removed    (skp_removed),
    .legacy_path    (legacy_rate),
    .code           (rx_status_code)
  ); // R8

  // Sticky copy of the last non-zero status code and the rate-done flag for software.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rxs_hold_q  <= `PPL_RXS_OK;
      rate_done_q <= 1'b0;
    end else begin
      if (rx_status_code != `PPL_RXS_OK)
        rxs_hold_q <= rx_status_code;
      if (sw_done)
        rate_done_q <= 1'b1;
      else if (status_w1c)
        rate_done_q <= 1'b0;
    end
  end

  // Lane outputs, registered so they change one edge after their cause.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_elec_idle              <= 1'b1;
      compliance_send           <= 1'b0;
      packet_enable             <= 1'b0;
      legacy_coding_datapath    <= 1'b1;
      high_rate_coding_datapath <= 1'b0;
      disparity_enable          <= 1'b1;
      parallel_width            <= `PPL_WIDTH_LEGACY;
      deemph_6db                <= 1'b0;
      tx_margin                 <= 3'h0;
      rate_match_enable         <= 1'b1;
      lane_bonded               <= 1'b0;
      lane_count                <= 5'h01;
      phy_status_pulse          <= 1'b0;
    end else begin
      // Idle on request, in every low-power state and through a rate switch.
      tx_elec_idle <= eidle_req || (pwr_state != `PPL_PWR_P0) ||
                      sw_busy; // R3 R6 R11
      packet_enable <= (pwr_state == `PPL_PWR_P0) && !sw_busy &&
                       !eidle_req; // R5
      compliance_send <= compl_req && legacy_rate && !sw_busy &&
                         (pwr_state == `PPL_PWR_P0); // R7
      legacy_coding_datapath    <= legacy_rate; // R14
      high_rate_coding_datapath <= !legacy_rate; // R14
      disparity_enable          <= legacy_rate; // R16
      parallel_width <= legacy_rate ? `PPL_WIDTH_LEGACY : `PPL_WIDTH_HIGH; // R15
      if (cur_rate != `PPL_RATE_2G5) begin
        deemph_6db <= !ctrl_q[`PPL_CTRL_DEEMPH_BIT]; // R20
        tx_margin  <= ctrl_q[`PPL_CTRL_MARGIN_LSB+2:`PPL_CTRL_MARGIN_LSB]; // R20
      end else begin
        deemph_6db <= 1'b0;
        tx_margin  <= 3'h0;
      end
      rate_match_enable <= !cfg_q[`PPL_CFG_PPM0_BIT]; // R21
      lane_count  <= width_lanes(cfg_q[`PPL_CFG_WIDTH_LSB+2:`PPL_CFG_WIDTH_LSB]); // R13
      lane_bonded <= (cfg_q[`PPL_CFG_WIDTH_LSB+2:`PPL_CFG_WIDTH_LSB] != 3'h0); // R12
      // The detect pulse waits one edge so it lines up with the detect status code.
      phy_status_pulse <= sw_done || det_valid_q; // R22
    end
  end

endmodule

/* File: hw/ppl_lane_defs.vh */
// Offsets, field positions, reset values and encodings for the PIPE lane control block.
`ifndef PPL_LANE_DEFS_VH
`define PPL_LANE_DEFS_VH

`define PPL_ADDR_W        12
`define PPL_ADDR_CTRL     12'h000
`define PPL_ADDR_CFG      12'h004
`define PPL_ADDR_STATUS   12'h008
`define PPL_ADDR_DETECT   12'h00C

`define PPL_CTRL_RATE_LSB   0
`define PPL_CTRL_PWR_LSB    2
`define PPL_CTRL_EIDLE_BIT  4
`define PPL_CTRL_DETECT_BIT 5
`define PPL_CTRL_COMPL_BIT  6
`define PPL_CTRL_DEEMPH_BIT 7
`define PPL_CTRL_MARGIN_LSB 8
`define PPL_CTRL_W          11
`define PPL_CTRL_RST        11'h014

`define PPL_CFG_MAXR_LSB    0
`define PPL_CFG_WIDTH_LSB   2
`define PPL_CFG_PPM0_BIT    5
`define PPL_CFG_W           6
`define PPL_CFG_RST         6'h02

`define PPL_RATE_2G5      2'h0
`define PPL_RATE_5G       2'h1
`define PPL_RATE_8G       2'h2

`define PPL_PWR_P0        2'h0
`define PPL_PWR_P0S       2'h1
`define PPL_PWR_P1        2'h2
`define PPL_PWR_P2        2'h3

`define PPL_RXS_OK        3'h0
`define PPL_RXS_SKP_ADD   3'h1
`define PPL_RXS_SKP_DEL   3'h2
`define PPL_RXS_DETECTED  3'h3
`define PPL_RXS_DEC_ERR   3'h4
`define PPL_RXS_OVERFLOW  3'h5
`define PPL_RXS_UNDERFLOW 3'h6
`define PPL_RXS_DISP_ERR  3'h7

`define PPL_WIDTH_LEGACY  6'h0A
`define PPL_WIDTH_HIGH    6'h20

`endif

/* File: hw/ppl_rate_switch.v */
// Rate switch sequencer: flush, hold coding reset, shut clocks, ask the analog side, release.
`timescale 1ns/10ps
`include "ppl_lane_defs.vh"
module ppl_rate_switch (
  input  wire       pclk,
  input  wire       presetn,
  input  wire       start,
  input  wire [1:0] target_rate,
  input  wire       tx_fifo_empty,
  input  wire       pma_done,
  output reg  [1:0] cur_rate,
  output reg  [1:0] pma_rate_req,
  output wire       pma_req_valid,
  output wire       coding_reset,
  output wire       clk_shutdown,
  output wire       busy,
  output reg        done_pulse
);
  localparam S_IDLE  = 5'b00001;
  localparam S_FLUSH = 5'b00010;
  localparam S_SHUT  = 5'b00100;
  localparam S_WAIT  = 5'b01000;
  localparam S_REL   = 5'b10000;

  reg [4:0] state_q;
  reg [4:0] state_d;

  always @* begin
    state_d = state_q;
    case (state_q)
      S_IDLE:  if (start) state_d = S_FLUSH;
      S_FLUSH: if (tx_fifo_empty) state_d = S_SHUT;
      S_SHUT:  state_d = S_WAIT;
      S_WAIT:  if (pma_done) state_d = S_REL;
      S_REL:   state_d = S_IDLE;
      default: state_d = S_IDLE;
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q      <= S_IDLE;
      cur_rate     <= `PPL_RATE_2G5;
      pma_rate_req <= `PPL_RATE_2G5;
      done_pulse   <= 1'b0;
    end else begin
      state_q    <= state_d;
      done_pulse <= (state_q == S_REL);
      if (state_q == S_IDLE && start)
        pma_rate_req <= target_rate;
      if (state_q == S_REL)
        cur_rate <= pma_rate_req;
    end
  end

  // Coding reset and clock shutdown cover the analog switch so no half-rate data leaks out.
  assign coding_reset  = (state_q == S_SHUT) || (state_q == S_WAIT) || (state_q == S_REL);
  assign clk_shutdown  = (state_q == S_SHUT) || (state_q == S_WAIT);
  assign pma_req_valid = (state_q == S_WAIT);
  assign busy          = (state_q != S_IDLE);
endmodule

/* File: hw/ppl_rx_status.v */
// Receiver status encoder merging coding-section flags and the far-end detect result.
`timescale 1ns/10ps
`include "ppl_lane_defs.vh"
module ppl_rx_status (
  input  wire       pclk,
  input  wire       presetn,
  input  wire       detect_done,
  input  wire       detect_present,
  input  wire       decode_err,
  input  wire       disparity_err,
  input  wire       fifo_overflow,
  input  wire       fifo_underflow,
  input  wire       skp_added,
  input  wire       skp_removed,
  input  wire       legacy_path,
  output reg  [2:0] code
);
  reg [2:0] code_d;

  always @* begin
    code_d = `PPL_RXS_OK;
    if (detect_done)
      code_d = detect_present ? `PPL_RXS_DETECTED : `PPL_RXS_OK;
    else if (legacy_path && decode_err)
      code_d = `PPL_RXS_DEC_ERR;
    else if (fifo_overflow)
      code_d = `PPL_RXS_OVERFLOW;
    else if (fifo_underflow)
      code_d = `PPL_RXS_UNDERFLOW;
    else if (legacy_path && disparity_err)
      code_d = `PPL_RXS_DISP_ERR;
    else if (skp_added)
      code_d = `PPL_RXS_SKP_ADD;
    else if (skp_removed)
      code_d = `PPL_RXS_SKP_DEL;
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      code <= `PPL_RXS_OK;
    else
      code <= code_d;
  end
endmodule

/* File: verification/ppl_analog_model.sv */
// Analog-side stand-in: answers rate requests and runs far-end receiver detection.
`timescale 1ns/10ps
module ppl_analog_model #(
  parameter int RATE_DLY = 6,
  parameter int DET_DLY  = 9
) (
  input  wire pclk,
  input  wire presetn,
  input  wire pma_req_valid,
  input  wire rx_detect_start,
  input  wire far_present,
  output wire pma_rate_done,
  output wire rx_detect_done,
  output wire rx_detect_present
);
  int rcnt;
  int dcnt;
  // Done stays high while the request stands and until the edge after it drops.
  assign pma_rate_done = rcnt >= RATE_DLY;
  assign rx_detect_done = dcnt >= DET_DLY;
  // Outside its result window the presence line carries the opposite value.
  assign rx_detect_present = rx_detect_done ? far_present : !far_present;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rcnt <= 0;
      dcnt <= 0;
    end else begin
      rcnt <= pma_req_valid ? rcnt + 1 : 0;
      if (rx_detect_start) begin
        dcnt <= 1;
      end else if (dcnt == DET_DLY + 3) begin
        dcnt <= 0;
      end else if (dcnt != 0) begin
        dcnt <= dcnt + 1;
      end
    end
  end
endmodule

/* File: verification/ppl_lane_ctrl_assertions.sv */
// Port-level assertions for the PIPE lane control block, bound to its top module.
`timescale 1ns/10ps
module ppl_lane_ctrl_chk (
  input wire        pclk,
  input wire        presetn,
  input wire        psel,
  input wire        penable,
  input wire [11:0] paddr,
  input wire [31:0] prdata,
  input wire        pslverr,
  input wire        pma_rate_done,
  input wire        rx_detect_done,
  input wire        rx_detect_present,
  input wire        decode_err,
  input wire [1:0]  pma_rate_req,
  input wire        pma_req_valid,
  input wire        coding_reset,
  input wire        clk_shutdown,
  input wire        tx_elec_idle,
  input wire        rx_detect_start,
  input wire        legacy_coding_datapath,
  input wire        high_rate_coding_datapath,
  input wire        disparity_enable,
  input wire [5:0]  parallel_width,
  input wire        deemph_6db,
  input wire [2:0]  tx_margin,
  input wire [2:0]  rx_status_code,
  input wire        phy_status_pulse
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_detect_one_pulse: assert property (rx_detect_start |=> !rx_detect_start)
    else $error("detect start longer than one cycle");
  a_detect_stays_idle: assert property (rx_detect_start |-> tx_elec_idle [*4])
    else $error("transmitter left idle during detection");
  a_status_one_pulse: assert property (phy_status_pulse |=> !phy_status_pulse)
    else $error("phy status pulse longer than one cycle");
  a_switch_shut_first: assert property ($rose(pma_req_valid) |-> coding_reset && clk_shutdown && tx_elec_idle)
    else $error("analog request before coding reset and clock shutdown");
  a_switch_req_stable: assert property (pma_req_valid |-> $stable(pma_rate_req))
    else $error("rate request changed while waiting");
  a_switch_done_pulse: assert property ($rose(pma_rate_done) && pma_req_valid |-> ##[2:10] phy_status_pulse)
    else $error("no status pulse after analog rate done");
  a_detect_found_code: assert property ($rose(rx_detect_done) && rx_detect_present
    |-> ##[2:6] (phy_status_pulse && rx_status_code == 3'h3))
    else $error("receiver detected code missing");
  a_high_rate_path: assert property (!coding_reset && high_rate_coding_datapath
    |-> parallel_width == 6'h20 && !disparity_enable && !legacy_coding_datapath)
    else $error("high rate path settings wrong");
  a_legacy_path_cfg: assert property (!coding_reset && legacy_coding_datapath
    |-> parallel_width == 6'h0A && disparity_enable)
    else $error("legacy path settings wrong");
  a_low_rate_emph: assert property (phy_status_pulse && pma_rate_req == 2'h0 |-> !deemph_6db && tx_margin == 3'h0)
    else $error("emphasis or margin active at lowest rate");
  a_decode_err_code: assert property (decode_err && legacy_coding_datapath && !rx_detect_done
    |=> rx_status_code == 3'h4)
    else $error("decode error code missing");
  a_unmapped_error: assert property (psel && !penable && paddr[11:4] != 8'h00 |=> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  c_rate_high: cover property (phy_status_pulse && high_rate_coding_datapath);
  c_analog_done: cover property ($rose(pma_rate_done));
  c_detect_run: cover property (rx_detect_start);
  c_bus_error: cover property (pslverr);
endmodule

bind ppl_lane_ctrl ppl_lane_ctrl_chk i_chk (.pclk, .presetn, .psel, .penable, .paddr, .prdata, .pslverr,
  .pma_rate_done, .rx_detect_done, .rx_detect_present, .decode_err, .pma_rate_req, .pma_req_valid,
  .coding_reset, .clk_shutdown, .tx_elec_idle, .rx_detect_start, .legacy_coding_datapath,
  .high_rate_coding_datapath, .disparity_enable, .parallel_width, .deemph_6db, .tx_margin,
  .rx_status_code, .phy_status_pulse);

/* File: verification/test_ppl_lane_ctrl.sv */
// Self-checking bench for the PIPE lane control block.
`timescale 1ns/10ps
`include "ppl_lane_defs.vh"
module test_ppl_lane_ctrl;
  localparam logic [11:0] CT = `PPL_ADDR_CTRL;
  localparam logic [11:0] CF = `PPL_ADDR_CFG;
  localparam logic [11:0] ST = `PPL_ADDR_STATUS;
  localparam logic [11:0] DT = `PPL_ADDR_DETECT;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic        tx_fifo_empty = 1'b1;
  logic        far_present = 1'b1;
  logic        perr;
  logic [1:0]  cur = 2'h0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] rd;
  logic [5:0]  ev = 6'h00;
  logic [1:0]  seq [6] = '{2'h1, 2'h0, 2'h2, 2'h1, 2'h2, 2'h0};
  logic [5:0]  evt [7] = '{6'h01, 6'h02, 6'h04, 6'h08, 6'h10, 6'h20, 6'h05};
  logic [2:0]  evc [7] = '{`PPL_RXS_DEC_ERR, `PPL_RXS_DISP_ERR, `PPL_RXS_OVERFLOW, `PPL_RXS_UNDERFLOW,
                           `PPL_RXS_SKP_ADD, `PPL_RXS_SKP_DEL, `PPL_RXS_DEC_ERR};
  int          n_mismatch = 0;
  int          cmp_count = 0;
  int          k;
  wire [31:0]  prdata;
  wire [5:0]   parallel_width;
  wire [4:0]   lane_count;
  wire [2:0]   tx_margin, rx_status_code;
  wire         pready, pslverr, pma_req_valid, pma_rate_done, rx_detect_done, rx_detect_present;
  wire         tx_elec_idle, rx_detect_start, compliance_send, packet_enable, legacy_coding_datapath;
  wire         high_rate_coding_datapath, disparity_enable, deemph_6db, lane_bonded, phy_status_pulse;
  wire         rate_match_enable;

  always #2 pclk = ~pclk;

  ppl_lane_ctrl i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .tx_fifo_empty, .pma_rate_done, .rx_detect_done, .rx_detect_present, .decode_err(ev[0]),
    .disparity_err(ev[1]), .fifo_overflow(ev[2]), .fifo_underflow(ev[3]), .skp_added(ev[4]),
    .skp_removed(ev[5]), .pma_rate_req(), .pma_req_valid, .coding_reset(), .clk_shutdown(), .tx_elec_idle,
    .rx_detect_start, .compliance_send, .packet_enable, .legacy_coding_datapath, .high_rate_coding_datapath,
    .disparity_enable, .parallel_width, .deemph_6db, .tx_margin, .rate_match_enable, .lane_bonded,
    .lane_count, .rx_status_code, .phy_status_pulse);

  ppl_analog_model i_pma (.pclk, .presetn, .pma_req_valid, .rx_detect_start, .far_present, .pma_rate_done,
    .rx_detect_done, .rx_detect_present);

  task automatic conclude();
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      n_mismatch++;
    end
  endtask

  // One APB transfer; read data and error are taken at the edge that sees pready.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (i == 20) begin
      n_mismatch++;
      conclude();
    end
    rd = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rc(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask

  task automatic wait_pulse();
    int i;
    for (i = 0; i < 200; i++) begin
      @(posedge pclk);
      if (phy_status_pulse === 1'b1) break;
    end
    if (i == 200) begin
      n_mismatch++;
      conclude();
    end
  endtask

  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rc(CT, 32'h14);
    rc(CF, 32'h2);
    rc(ST, 32'h80);
    chk({tx_elec_idle, legacy_coding_datapath, high_rate_coding_datapath, disparity_enable, parallel_width},
        {4'hD, `PPL_WIDTH_LEGACY});
    apb(1'b0, 12'h010, 32'h0);
    chk(rd, 32'h0);
    chk({31'h0, perr}, 32'h1);
    for (k = 0; k < 5; k++) begin
      wr(CF, 32'(k * 4 + 2 + 32 * k[2]));
      rc(CF, 32'(k * 4 + 2 + 32 * k[2]));
      chk({rate_match_enable, lane_bonded, lane_count}, {!k[2], k != 0, 5'(1 << k)});
    end
    for (k = 0; k < 6; k++) begin
      tx_fifo_empty <= 1'b0;
      wr(CT, {21'h0, 3'h5, 6'h00, seq[k]});
      rc(CT, {21'h0, 3'h5, 6'h00, seq[k]});
      rc(ST, {20'h0, 5'h10, 1'b0, 3'h0, 1'b1, cur});
      tx_fifo_empty <= 1'b1;
      wait_pulse();
      cur = seq[k];
      rc(ST, {20'h0, 5'h10, 1'b1, 3'h0, 1'b0, cur});
      wr(ST, 32'h80);
      chk({legacy_coding_datapath, high_rate_coding_datapath, disparity_enable, parallel_width},
          (cur == 2'h2) ? {3'h2, `PPL_WIDTH_HIGH} : {3'h5, `PPL_WIDTH_LEGACY});
      chk({deemph_6db, tx_margin, packet_enable, tx_elec_idle}, (cur == 2'h0) ? 6'h02 : 6'h36);
    end
    for (k = 0; k < 4; k++) begin
      wr(CT, 32'(k * 4));
      rc(CT, 32'(k * 4));
      chk({packet_enable, tx_elec_idle}, (k == 0) ? 2'h2 : 2'h1);
    end
    wr(CT, 32'h10);
    rc(CT, 32'h10);
    chk(tx_elec_idle, 1'b1);
    wr(CT, 32'h40);
    rc(CT, 32'h40);
    chk({compliance_send, tx_elec_idle}, 2'h2);
    for (k = 1; k >= 0; k--) begin
      far_present <= k[0];
      wr(CT, 32'h08);
      wr(CT, 32'h28);
      wait_pulse();
      chk({tx_elec_idle, rx_status_code}, {2'h2, k[0], k[0]});
      rc(DT, {29'h0, 1'b1, k[0], 1'b0});
      wr(DT, 32'h4);
    end
    for (k = 0; k < 7; k++) begin
      @(posedge pclk);
      ev <= evt[k];
      @(posedge pclk);
      ev <= 6'h00;
      @(posedge pclk);
      chk(rx_status_code, evc[k]);
    end
    rc(ST, 32'h820);
    conclude();
  end
endmodule
